// file: rtl/card_event_consts.vh
// Constants for the card status-change event and window-enable block
`ifndef CARD_EVENT_CONSTS_VH
`define CARD_EVENT_CONSTS_VH

// Register indexes inside one socket's compatibility register set
`define IDX_EVENT_FLAGS      6'h04
`define IDX_EVENT_MASK_ROUTE 6'h05
`define IDX_WINDOW_ENABLES   6'h06

// Address map: index space bit 6 picks the socket, memory copy at base + 800h
`define IDX_SOCKET_BIT       6
`define MEM_REGS_BASE        12'h800
`define MEM_REGS_BASE_HI     6'h20

// Flag and mask bit positions
`define BIT_DETECT_CHANGE    3
`define BIT_READY_RISE       2
`define BIT_BATTERY_LOW      1
`define BIT_BATTERY_DEAD     0
`define FLAG_BITS_USED       4'hf

// Route select field in the mask/route register
`define SEL_LSB              4
`define SEL_MSB              7
`define SEL_NONE             4'h0
`define SEL_MGMT_INT         4'h2

// Window enable register: bit 5 is reserved
`define WIN_WRITABLE         8'hdf

// Reset values
`define RST_FLAGS            4'h0
`define RST_MASK_ROUTE       8'h00
`define RST_WINDOWS          8'h00
`define RST_BYTE             8'h00

`endif

// file: rtl/pin_change_sync.v
// Three-stage pin synchroniser with agreement filter and edge outputs
`timescale 1ns/1ps
module pin_change_sync (
	// Clock and reset
	input  wire i_clk,
	input  wire i_rst,
	// Asynchronous pin
	input  wire i_pin,
	// Filtered level and one-cycle edge pulses
	output reg  o_level,
	output reg  o_rise,
	output reg  o_fall
);

	reg s1_q;
	reg s2_q;
	reg s3_q;
	reg primed_q;

	// First stage feeds only the second stage
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else begin
			s1_q <= i_pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Level changes only once stages two and three agree; the first load after reset is silent
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_level  <= 1'b0;
			o_rise   <= 1'b0;
			o_fall   <= 1'b0;
			primed_q <= 1'b0;
		end else begin
			o_rise <= 1'b0;
			o_fall <= 1'b0;
			if (s2_q == s3_q) begin
				primed_q <= 1'b1;
				o_level  <= s3_q;
				if (primed_q && (s3_q != o_level)) begin
					o_rise <= s3_q;
					o_fall <= ~s3_q;
				end
			end
		end
	end

endmodule // pin_change_sync

// file: rtl/card_status_change_irq.v
// Two-socket card status-change flags, masking, interrupt routing and window claim gating
`timescale 1ns/1ps
`include "card_event_consts.vh"
module card_status_change_irq (
	// Clock and reset
	input  wire        i_clk,
	input  wire        i_rst,
	// Register access: index space or memory-mapped copy
	input  wire        i_acc_mem,
	input  wire        i_acc_sock,
	input  wire [11:0] i_addr,
	input  wire        i_wr,
	input  wire        i_rd,
	input  wire [7:0]  i_wdata,
	output reg  [7:0]  o_rdata,
	output reg         o_rvalid,
	// Control bits held elsewhere, one per socket unless global
	input  wire        i_flag_clear_by_write,
	input  wire [1:0]  i_card_kind_select,
	input  wire [1:0]  i_ring_mode_enable,
	input  wire [1:0]  i_event_route_to_host_bus,
	// Card pins, one per socket
	input  wire [1:0]  i_card_detect_a,
	input  wire [1:0]  i_card_detect_b,
	input  wire [1:0]  i_card_ready,
	input  wire [1:0]  i_battery_low,
	input  wire [1:0]  i_card_status_signal,
	// Window hits from address compare, layout as window enable register
	input  wire [7:0]  i_win_hit_a,
	input  wire [7:0]  i_win_hit_b,
	output wire [1:0]  o_claim,
	// Interrupt outputs
	output reg  [15:0] o_host_irq,
	output reg         o_system_mgmt_interrupt,
	output reg         o_host_bus_irq
);

	// Register index match, shared by the address decode and the flag-clear decode
	function idx_match;
		input [5:0] idx;
		input [5:0] want;
		begin
			idx_match = (idx == want);
		end
	endfunction

	// Decode of an access into {hit, socket, index}
	function [7:0] decode_access;
		input        mem;
		input        sock;
		input [11:0] addr;
		reg   [5:0]  idx;
		reg          hit;
		reg          s;
		begin
			idx = addr[5:0];
			hit = 1'b0;
			s   = 1'b0;
			if (mem) begin
				s   = sock;
				hit = (addr[11:6] == `MEM_REGS_BASE_HI);
			end else begin
				s   = addr[`IDX_SOCKET_BIT];
				hit = (addr[11:7] == 5'h00);
			end
			if (!idx_match(idx, `IDX_EVENT_FLAGS) && !idx_match(idx, `IDX_EVENT_MASK_ROUTE) &&
				!idx_match(idx, `IDX_WINDOW_ENABLES)) begin
				hit = 1'b0;
			end
			decode_access = {hit, s, idx};
		end
	endfunction

	// Route select decode into {management interrupt, host IRQ lines}
	// Codes 0 and 2 never reach a host line, so lines 0 and 2 stay idle
	function [16:0] route_decode;
		input [3:0] sel;
		reg   [16:0] r;
		begin
			r = 17'h00000;
			if (sel == `SEL_MGMT_INT) begin
				r[16] = 1'b1;
			end else if (sel != `SEL_NONE) begin
				r[sel] = 1'b1;
			end
			route_decode = r;
		end
	endfunction

	wire [7:0] acc_dec;
	wire       acc_hit;
	wire       acc_sock;
	wire [5:0] acc_idx;

	assign acc_dec  = decode_access(i_acc_mem, i_acc_sock, i_addr);
	assign acc_hit  = acc_dec[7];
	assign acc_sock = acc_dec[6];
	assign acc_idx  = acc_dec[5:0];

	wire       acc_flags;
	wire       clr_by_rd;
	wire       clr_by_wr;

	assign acc_flags = acc_hit && idx_match(acc_idx, `IDX_EVENT_FLAGS);
	// Only one clear method is live at a time; the other leaves the flags alone
	assign clr_by_rd = acc_flags && i_rd && !i_flag_clear_by_write;
	assign clr_by_wr = acc_flags && i_wr && i_flag_clear_by_write;

	// Per-socket read values and interrupt requests
	wire [7:0]  flags_rd [0:1];
	wire [7:0]  mask_rd  [0:1];
	wire [7:0]  win_rd   [0:1];
	wire [1:0]  sock_event;
	wire [16:0] sock_route [0:1];
	wire [7:0]  win_hit  [0:1];

	assign win_hit[0] = i_win_hit_a;
	assign win_hit[1] = i_win_hit_b;

	genvar gs;
	generate
		for (gs = 0; gs < 2; gs = gs + 1) begin : sock
			wire       cda_lvl;
			wire       cda_rise;
			wire       cda_fall;
			wire       cdb_lvl;
			wire       cdb_rise;
			wire       cdb_fall;
			wire       rdy_lvl;
			wire       rdy_rise;
			wire       rdy_fall;
			wire       bl_lvl;
			wire       bl_rise;
			wire       bl_fall;
			wire       st_lvl;
			wire       st_rise;
			wire       st_fall;
			reg  [3:0] flags_q;
			reg  [3:0] flags_d;
			reg  [7:0] mask_q;
			reg  [7:0] win_q;
			reg  [3:0] set_ev;
			reg  [3:0] clr_ev;
			reg  [3:0] flags_vis;
			wire       io_card;
			wire       ring_mode;
			wire       sel_me;
			wire       wr_me;
			wire       rd_me;
			wire [3:0] sel_field;

			// Each pin passes the three-stage filter, so an edge reaches the flags five clocks later
			pin_change_sync u_sync_cda (
				.i_clk   (i_clk),
				.i_rst   (i_rst),
				.i_pin   (i_card_detect_a[gs]),
				.o_level (cda_lvl),
				.o_rise  (cda_rise),
				.o_fall  (cda_fall)
			);
			pin_change_sync u_sync_cdb (
				.i_clk   (i_clk),
				.i_rst   (i_rst),
				.i_pin   (i_card_detect_b[gs]),
				.o_level (cdb_lvl),
				.o_rise  (cdb_rise),
				.o_fall  (cdb_fall)
			);
			pin_change_sync u_sync_rdy (
				.i_clk   (i_clk),
				.i_rst   (i_rst),
				.i_pin   (i_card_ready[gs]),
				.o_level (rdy_lvl),
				.o_rise  (rdy_rise),
				.o_fall  (rdy_fall)
			);
			pin_change_sync u_sync_bl (
				.i_clk   (i_clk),
				.i_rst   (i_rst),
				.i_pin   (i_battery_low[gs]),
				.o_level (bl_lvl),
				.o_rise  (bl_rise),
				.o_fall  (bl_fall)
			);
			pin_change_sync u_sync_st (
				.i_clk   (i_clk),
				.i_rst   (i_rst),
				.i_pin   (i_card_status_signal[gs]),
				.o_level (st_lvl),
				.o_rise  (st_rise),
				.o_fall  (st_fall)
			);

			assign io_card   = i_card_kind_select[gs];
			assign ring_mode = i_ring_mode_enable[gs];
			assign sel_me    = acc_hit && (acc_sock == gs);
			assign wr_me     = sel_me && i_wr;
			assign rd_me     = sel_me && i_rd;
			assign sel_field = mask_q[`SEL_MSB:`SEL_LSB];

			// Event detection and clearing
			always @* begin
				set_ev = 4'h0;
				clr_ev = 4'h0;
				set_ev[`BIT_DETECT_CHANGE] = (cda_rise | cda_fall | cdb_rise | cdb_fall) &
					mask_q[`BIT_DETECT_CHANGE];
				set_ev[`BIT_READY_RISE] = rdy_rise & ~io_card & mask_q[`BIT_READY_RISE];
				set_ev[`BIT_BATTERY_LOW] = bl_rise & ~io_card & mask_q[`BIT_BATTERY_LOW];
				set_ev[`BIT_BATTERY_DEAD] = st_rise & ~ring_mode & mask_q[`BIT_BATTERY_DEAD];
				if (clr_by_wr && wr_me) begin
					clr_ev = i_wdata[3:0] & `FLAG_BITS_USED;
				end
				if (clr_by_rd && rd_me) begin
					clr_ev = `FLAG_BITS_USED;
				end
				// Set wins over clear so no event is lost
				flags_d = (flags_q & ~clr_ev) | set_ev;
			end

			// Visible flags: masked sources and card-kind exclusions read 0
			always @* begin
				flags_vis = flags_q & mask_q[3:0];
				if (io_card) begin
					flags_vis[`BIT_READY_RISE]  = 1'b0;
					flags_vis[`BIT_BATTERY_LOW] = 1'b0;
				end
				if (ring_mode) begin
					flags_vis[`BIT_BATTERY_DEAD] = st_lvl & mask_q[`BIT_BATTERY_DEAD];
				end
			end

			always @(posedge i_clk or posedge i_rst) begin
				if (i_rst) begin
					flags_q <= `RST_FLAGS;
					mask_q  <= `RST_MASK_ROUTE;
					win_q   <= `RST_WINDOWS;
				end else begin
					flags_q <= flags_d;
					if (wr_me && (acc_idx == `IDX_EVENT_MASK_ROUTE)) begin
						mask_q <= i_wdata;
					end
					if (wr_me && (acc_idx == `IDX_WINDOW_ENABLES)) begin
						win_q <= i_wdata & `WIN_WRITABLE;
					end
				end
			end

			assign flags_rd[gs]   = {4'h0, flags_vis};
			assign mask_rd[gs]    = mask_q;
			assign win_rd[gs]     = win_q;
			assign sock_event[gs] = |flags_vis;
			assign sock_route[gs] = i_event_route_to_host_bus[gs] ? 17'h00000 :
				route_decode(sel_field);
			assign o_claim[gs]    = |(win_hit[gs] & win_q & `WIN_WRITABLE);
		end
	endgenerate

	// Read data, one cycle after the read is taken
	reg [7:0] rd_sel;

	always @* begin
		rd_sel = `RST_BYTE;
		case (acc_idx)
			`IDX_EVENT_FLAGS: begin
				rd_sel = flags_rd[acc_sock];
			end
			`IDX_EVENT_MASK_ROUTE: begin
				rd_sel = mask_rd[acc_sock];
			end
			`IDX_WINDOW_ENABLES: begin
				rd_sel = win_rd[acc_sock];
			end
			default: begin
				rd_sel = `RST_BYTE;
			end
		endcase
		if (!acc_hit) begin
			rd_sel = `RST_BYTE;
		end
	end

	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rdata  <= `RST_BYTE;
			o_rvalid <= 1'b0;
		end else begin
			o_rvalid <= i_rd;
			if (i_rd) begin
				o_rdata <= rd_sel;
			end
		end
	end

	// Interrupt routing, registered
	// Both sockets may pick the same line; their requests simply OR together
	wire [16:0] route_0;
	wire [16:0] route_1;

	assign route_0 = sock_event[0] ? sock_route[0] : 17'h00000;
	assign route_1 = sock_event[1] ? sock_route[1] : 17'h00000;

	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_host_irq              <= 16'h0000;
			o_system_mgmt_interrupt <= 1'b0;
			o_host_bus_irq          <= 1'b0;
		end else begin
			o_host_irq              <= route_0[15:0] | route_1[15:0];
			o_system_mgmt_interrupt <= route_0[16] | route_1[16];
			o_host_bus_irq          <= |(sock_event & i_event_route_to_host_bus);
		end
	end

endmodule // card_status_change_irq

// file: bench/card_status_change_irq_checker.sv
// Checker for the card status-change event block ports
`timescale 1ns/1ps
module card_status_change_irq_checker (
	// Clock, reset and register bus
	input  wire        i_clk,
	input  wire        i_rst,
	input  wire        i_rd,
	input  wire        i_acc_mem,
	input  wire [11:0] i_addr,
	input  wire [7:0]  o_rdata,
	input  wire        o_rvalid,
	// Windows and interrupts
	input  wire [7:0]  i_win_hit_a,
	input  wire [7:0]  i_win_hit_b,
	input  wire [1:0]  o_claim,
	input  wire [15:0] o_host_irq,
	input  wire        o_system_mgmt_interrupt
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	read_answer_a: assert property (o_rvalid == $past(i_rd)) else $error("read answer late");
	rdata_hold_a: assert property (!o_rvalid |-> $stable(o_rdata)) else $error("read data moved");
	flag_upper_a: assert property (o_rvalid && $past(i_addr[5:0]) == 6'h04 |-> o_rdata[7:4] == 4'h0)
		else $error("flag upper bits set");
	unmapped_zero_a: assert property (o_rvalid && !($past(i_addr[5:0]) inside {[6'h04:6'h06]}) |-> o_rdata == 8'h00)
		else $error("unmapped read not zero");
	claim_a_a: assert property (o_claim[0] |-> |i_win_hit_a) else $error("socket a claim without hit");
	claim_b_a: assert property (o_claim[1] |-> |i_win_hit_b) else $error("socket b claim without hit");
	reset_quiet_a: assert property ($fell(i_rst) |-> o_claim == 2'b00 && o_host_irq == 16'h0000)
		else $error("outputs busy after reset");
	irq_unused_a: assert property (!o_host_irq[0] && !o_host_irq[2]) else $error("unused irq line driven");
	cover property (o_system_mgmt_interrupt);
	cover property (|o_claim);
	cover property (o_rvalid && o_rdata[3]);
endmodule // card_status_change_irq_checker

// file: bench/card_model.sv
// Model of the cards in both sockets, driving their status pins
`timescale 1ns/1ps
module card_model (
	// Clock
	input  wire       i_clk,
	// Card pins, one bit per socket
	output reg  [1:0] o_detect_a,
	output reg  [1:0] o_detect_b,
	output reg  [1:0] o_ready,
	output reg  [1:0] o_battery_low,
	output reg  [1:0] o_status
);
	initial {o_detect_a, o_detect_b, o_ready, o_battery_low, o_status} = 10'h000;
	// Pins move just after an edge, unrelated to any access
	task drive(input s, input [4:0] v);
		begin
			@(posedge i_clk) #1;
			{o_detect_a[s], o_detect_b[s], o_ready[s], o_battery_low[s], o_status[s]} = v;
		end
	endtask
endmodule // card_model

// file: bench/card_status_change_irq_tb_top.sv
// Testbench for the card status-change event block
`timescale 1ns/1ps
module card_status_change_irq_tb_top;
	reg         i_clk = 0, i_rst = 1, i_acc_mem = 0, i_acc_sock = 0, i_wr = 0, i_rd = 0;
	reg         i_flag_clear_by_write = 0;
	reg  [11:0] i_addr = 0;
	reg  [7:0]  i_wdata = 0, i_win_hit_a = 0, i_win_hit_b = 0, r, en [0:1];
	reg  [1:0]  i_card_kind_select = 0, i_ring_mode_enable = 0, i_event_route_to_host_bus = 0;
	reg  [31:0] seed = 26647, x;
	reg  [4:0]  pv;
	wire [1:0]  cda, cdb, rdy, bat, sts, o_claim;
	wire [7:0]  o_rdata;
	wire [15:0] o_host_irq;
	wire        o_rvalid, o_system_mgmt_interrupt, o_host_bus_irq;
	integer     mismatches = 0, checks = 0, cyc = 0, s, b, k;
	card_status_change_irq u_card_status_change_irq (.i_clk, .i_rst, .i_acc_mem, .i_acc_sock, .i_addr,
		.i_wr, .i_rd, .i_wdata, .o_rdata, .o_rvalid, .i_flag_clear_by_write, .i_card_kind_select,
		.i_ring_mode_enable, .i_event_route_to_host_bus, .i_card_detect_a(cda), .i_card_detect_b(cdb),
		.i_card_ready(rdy), .i_battery_low(bat), .i_card_status_signal(sts), .i_win_hit_a, .i_win_hit_b,
		.o_claim, .o_host_irq, .o_system_mgmt_interrupt, .o_host_bus_irq);
	card_model u_card_model (.i_clk, .o_detect_a(cda), .o_detect_b(cdb), .o_ready(rdy),
		.o_battery_low(bat), .o_status(sts));
	always #25 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		cyc = cyc + 1;
		if (cyc == 6000) begin
			mismatches = mismatches + 1;
			test_done;
		end
	end
	function [31:0] xs(input d);
		begin
			seed = seed ^ (seed << 13);
			seed = seed ^ (seed >> 17);
			seed = seed ^ (seed << 5);
			xs = seed;
		end
	endfunction
	task chk(input [17:0] g, input [17:0] e);
		begin
			checks = checks + 1;
			if (g !== e) begin
				mismatches = mismatches + 1;
				$display("Error at %0t: got %h expected %h", $time, g, e);
			end
		end
	endtask
	// One register access; read data lands one cycle after the strobe
	task acc(input w, input m, input sk, input [5:0] a, input [7:0] d);
		begin
			@(posedge i_clk) #1;
			{i_acc_mem, i_acc_sock, i_wdata, i_wr, i_rd} = {m, sk, d, w, !w};
			i_addr = m ? {6'h20, a} : {5'h00, sk, a};
			@(posedge i_clk) #1;
			{i_wr, i_rd} = 2'b00;
			r = o_rdata;
		end
	endtask
	task rd(input sk, input [5:0] a, input [7:0] e);
		begin
			acc(0, 0, sk, a, 8'h00);
			chk(r, e);
		end
	endtask
	task ev(input sk, input [4:0] v);
		begin
			u_card_model.drive(sk, v);
			repeat (8) @(posedge i_clk);
			#1;
		end
	endtask
	task test_done;
		begin
			$display("checks %0d mismatches %0d", checks, mismatches);
			if (mismatches == 0 && checks > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask
	initial begin
		en[0] = 8'h00;
		en[1] = 8'h00;
		repeat (8) @(posedge i_clk);
		#1 i_rst = 0;
		repeat (4) @(posedge i_clk);
		for (k = 0; k < 6; k = k + 1) rd(k[0], 6'h04 + k / 2, 8'h00);
		for (k = 0; k < 8; k = k + 1) begin
			x = xs(0);
			acc(1, k[1], k[0], 6'h05 + k[2], x[7:0]);
			acc(0, !k[1], k[0], 6'h05 + k[2], 8'h00);
			if (k[2]) en[k[0]] = x[7:0] & 8'hdf;
			chk(r, k[2] ? en[k[0]] : x[7:0]);
			{i_win_hit_a, i_win_hit_b} = xs(0);
			#1 chk(o_claim, {|(i_win_hit_b & en[1]), |(i_win_hit_a & en[0])});
		end
		acc(1, 0, 0, 6'h04, 8'hff);
		rd(0, 6'h04, 8'h00);
		rd(0, 6'h3f, 8'h00);
		for (s = 0; s < 2; s = s + 1) begin
			acc(1, 0, s, 6'h05, {4'h3 + s[3:0], 4'hf});
			pv = 5'h00;
			for (b = 3; b >= 0; b = b - 1) begin
				pv = pv | (b == 3 ? 5'h10 : 5'h01 << b);
				ev(s, pv);
				chk(o_host_irq, 16'h0008 << s);
				rd(s, 6'h04, 8'h01 << b);
				rd(s, 6'h04, 8'h00);
				chk(o_host_irq, 16'h0000);
			end
			ev(s, 5'h10);
			rd(s, 6'h04, 8'h00);
			acc(1, 0, s, 6'h05, {4'h3 + s[3:0], 4'h0});
			ev(s, 5'h0f);
			rd(s, 6'h04, 8'h00);
			chk(o_host_irq, 16'h0000);
			acc(1, 0, s, 6'h05, {4'h3 + s[3:0], 4'hf});
			rd(s, 6'h04, 8'h00);
			ev(s, 5'h00);
			rd(s, 6'h04, 8'h08);
			i_card_kind_select = 2'b11;
			ev(s, 5'h06);
			rd(s, 6'h04, 8'h00);
			ev(s, 5'h07);
			rd(s, 6'h04, 8'h01);
			ev(s, 5'h00);
			rd(s, 6'h04, 8'h00);
			i_card_kind_select = 2'b00;
		end
		i_flag_clear_by_write = 1;
		ev(0, 5'h08);
		rd(0, 6'h04, 8'h08);
		acc(1, 0, 0, 6'h04, 8'hf7);
		rd(0, 6'h04, 8'h08);
		acc(1, 0, 0, 6'h04, 8'h08);
		rd(0, 6'h04, 8'h00);
		i_flag_clear_by_write = 0;
		ev(0, 5'h00);
		rd(0, 6'h04, 8'h08);
		for (k = 0; k < 16; k = k + 1) begin
			x = xs(0);
			i_event_route_to_host_bus = {1'b0, x[0]};
			acc(1, 0, 0, 6'h05, {k[3:0], 4'h8});
			ev(0, {!k[0], 4'h0});
			chk({o_host_bus_irq, o_system_mgmt_interrupt, o_host_irq},
				{x[0], !x[0] && k == 2, (x[0] || k == 0 || k == 2) ? 16'h0000 : 16'h0001 << k});
			rd(0, 6'h04, 8'h08);
		end
		i_event_route_to_host_bus = 2'b00;
		i_ring_mode_enable = 2'b01;
		acc(1, 0, 0, 6'h05, 8'h31);
		ev(0, 5'h01);
		rd(0, 6'h04, 8'h01);
		rd(0, 6'h04, 8'h01);
		ev(0, 5'h00);
		rd(0, 6'h04, 8'h00);
		test_done;
	end
endmodule // card_status_change_irq_tb_top
bind card_status_change_irq card_status_change_irq_checker u_card_status_change_irq_checker (.i_clk, .i_rst,
	.i_rd, .i_acc_mem, .i_addr, .o_rdata, .o_rvalid, .i_win_hit_a, .i_win_hit_b, .o_claim, .o_host_irq,
	.o_system_mgmt_interrupt);
